//--- logic/dmsc_defs.vh
`ifndef DMSC_DEFS_VH
`define DMSC_DEFS_VH

// Register byte addresses
`define DMSC_A_CTRL 8'h00
`define DMSC_A_STATUS 8'h04
`define DMSC_A_RIGHTS 8'h08
`define DMSC_A_FSIZE 8'h0C
`define DMSC_A_IDOFS 8'h10
`define DMSC_A_CTROFS 8'h14
`define DMSC_A_CARDOFS 8'h18
`define DMSC_A_TAMPOFS 8'h1C
`define DMSC_A_AINOFS 8'h20
`define DMSC_A_ENCOFS 8'h24
`define DMSC_A_ENCLEN 8'h28
`define DMSC_A_AUTHOFS 8'h2C
`define DMSC_A_LIMIT 8'h30
`define DMSC_A_OPT 8'h34
`define DMSC_A_STORED 8'h38

// Option byte bits
`define DMSC_OPT_IDENT 7
`define DMSC_OPT_CTR 6
`define DMSC_OPT_LIMIT 5
`define DMSC_OPT_ENC 4
`define DMSC_OPT_TAMPER 3
`define DMSC_OPT_ASCII 0

// Control bits
`define DMSC_CTRL_GO 0
`define DMSC_CTRL_BUSY_OTHER 1
`define DMSC_CTRL_MAC_BAD 2
`define DMSC_CTRL_LEN_BAD 3

// Status codes
`define DMSC_SW1 8'h91
`define DMSC_OK 8'h00
`define DMSC_ABORTED 8'hCA
`define DMSC_INTEGRITY 8'h1E
`define DMSC_LENGTH 8'h7E
`define DMSC_PARAM 8'h9E

// Rights and lengths
`define DMSC_NO_RIGHT 4'hF
`define DMSC_FREE_RIGHT 4'hE
`define DMSC_MAX_KEY 4'h4
`define DMSC_TAMPER_LEN 24'h000002
`define DMSC_AUTH_LEN 24'h000010
`define DMSC_ENC_UNIT 24'h000020
`define DMSC_IDENT_LEN 24'h00000E
`define DMSC_CTR_LEN 24'h000006
`define DMSC_CARD_LEN 24'h000020

`endif

//--- logic/dmsc_check.v
// Summary of operation
// - Card data offset within file minus length
// - Tamper offset within file minus two
// - Auth input start not beyond auth offset
// - Cipher offset between input start, auth-32
// - Cipher length multiple of 32, fits
// - No cipher: auth offset input..size-16
// - Cipher: auth offset after region..size-16
// - Counter limit any value, with bit 5
// - Success 9100h, failure 91 plus code
// - Busy chained command gives CAh
// - Bad command MAC gives 1Eh
// - Bad command size gives 7Eh
// - Range or missing key gives 9Eh
// - Meta right set without mirrors errs
// - Meta right Fh with identifier errs
// - Counter right set without counter errs
// - Auth field overlapping mirrors errs
// - Cipher region overlapping identifier errs
// - Option byte bit enables tamper mirror; ident, counter mirrors also need meta right Eh; card mirror by meta key
// - Meta right selects key, plain, none
`timescale 1ns/1ns
`default_nettype none
`include "dmsc_defs.vh"

module dmsc_check #(
   parameter AW = 8
) (
   input wire clock,
   input wire rstn,
   input wire [AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   reg [3:0] ctrl;
   reg [15:0] rights;
   reg [23:0] fsize, id_ofs, ctr_ofs, card_ofs, tamp_ofs;
   reg [23:0] ain_ofs, enc_ofs, enc_len, auth_ofs, limit;
   reg [7:0] opt;
   reg [15:0] status_word;
   reg done;
   // Committed settings, only written on success
   reg [7:0] stored_opt;
   reg [15:0] stored_rights;

   reg [AW-1:0] wa;
   reg wa_ok, wd_ok;
   reg [31:0] wd;
   reg [3:0] ws;

   // Byte-lane merge for partially strobed writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
         end
      end
   endfunction

   // True when ranges [a, a+la) and [b, b+lb) share a byte
   function overlap;
      input [23:0] a;
      input [23:0] la;
      input [23:0] b;
      input [23:0] lb;
      begin
         overlap = !(({1'b0, a} >= {1'b0, b} + {1'b0, lb}) ||
                     ({1'b0, b} >= {1'b0, a} + {1'b0, la}));
      end
   endfunction

   // True when v lies in [lo, hi] with hi computed without wrap
   function in_range;
      input [24:0] v;
      input [24:0] lo;
      input [25:0] hi;
      begin
         in_range = !hi[25] && (v >= lo) && ({1'b0, v} <= hi);
      end
   endfunction

   // Key numbers past the last key, other than free and none, are unknown
   function bad_key;
      input [3:0] r;
      begin
         bad_key = (r > `DMSC_MAX_KEY) && (r != `DMSC_FREE_RIGHT) &&
                   (r != `DMSC_NO_RIGHT);
      end
   endfunction

   wire [3:0] meta_read_right = rights[15:12];
   wire [3:0] file_read_right = rights[11:8];
   wire [3:0] counter_retrieve_right = rights[3:0];
   wire ident_on = opt[`DMSC_OPT_IDENT];
   wire ctr_on = opt[`DMSC_OPT_CTR];
   wire enc_on = opt[`DMSC_OPT_ENC];
   wire tamp_on = opt[`DMSC_OPT_TAMPER];
   wire card_on = meta_read_right <= `DMSC_MAX_KEY;
   wire plain_meta = meta_read_right == `DMSC_FREE_RIGHT;
   wire id_on = ident_on && plain_meta;
   wire ct_on = ctr_on && plain_meta;
   wire sdm_on = file_read_right != `DMSC_NO_RIGHT;
   wire cipher_on = sdm_on && enc_on;
   wire [25:0] fs = {2'b00, fsize};

   // Any failing parameter check raises the parameter error
   reg perr;
   reg [24:0] enc_end;
   always @* begin
      perr = 1'b0;
      enc_end = {1'b0, enc_ofs} + {1'b0, enc_len};
      if (bad_key(meta_read_right) || bad_key(file_read_right) ||
          bad_key(counter_retrieve_right) ||
          file_read_right == `DMSC_FREE_RIGHT)
         perr = 1'b1;
      if (meta_read_right != `DMSC_NO_RIGHT && !ident_on && !ctr_on)
         perr = 1'b1;
      if (meta_read_right == `DMSC_NO_RIGHT && ident_on)
         perr = 1'b1;
      if (counter_retrieve_right != `DMSC_NO_RIGHT && !ctr_on)
         perr = 1'b1;
      if (card_on && !in_range({1'b0, card_ofs}, 25'd0,
                               fs - {2'b00, `DMSC_CARD_LEN}))
         perr = 1'b1;
      if (tamp_on && !in_range({1'b0, tamp_ofs}, 25'd0,
                               fs - {2'b00, `DMSC_TAMPER_LEN}))
         perr = 1'b1;
      if (id_on && !in_range({1'b0, id_ofs}, 25'd0,
                             fs - {2'b00, `DMSC_IDENT_LEN}))
         perr = 1'b1;
      if (ct_on && !in_range({1'b0, ctr_ofs}, 25'd0,
                             fs - {2'b00, `DMSC_CTR_LEN}))
         perr = 1'b1;
      if (sdm_on) begin
         if (ain_ofs > auth_ofs)
            perr = 1'b1;
         if (cipher_on) begin
            if (!in_range({1'b0, enc_ofs}, {1'b0, ain_ofs},
                          {2'b00, auth_ofs} -
                          {2'b00, `DMSC_ENC_UNIT}))
               perr = 1'b1;
            if (enc_len < `DMSC_ENC_UNIT || enc_len[4:0] != 5'h00 ||
                !in_range({1'b0, enc_len}, 25'd0,
                          {2'b00, auth_ofs} - {2'b00, enc_ofs}))
               perr = 1'b1;
            if (!in_range({1'b0, auth_ofs}, enc_end,
                          fs - {2'b00, `DMSC_AUTH_LEN}))
               perr = 1'b1;
            if (id_on && overlap(enc_ofs, enc_len, id_ofs,
                                 `DMSC_IDENT_LEN))
               perr = 1'b1;
         end else if (!in_range({1'b0, auth_ofs}, {1'b0, ain_ofs},
                                fs - {2'b00, `DMSC_AUTH_LEN}))
            perr = 1'b1;
         // The authentication field may not share a byte with any mirror
         if ((id_on && overlap(auth_ofs, `DMSC_AUTH_LEN, id_ofs,
                               `DMSC_IDENT_LEN)) ||
             (ct_on && overlap(auth_ofs, `DMSC_AUTH_LEN, ctr_ofs,
                               `DMSC_CTR_LEN)) ||
             (card_on && overlap(auth_ofs, `DMSC_AUTH_LEN, card_ofs,
                                 `DMSC_CARD_LEN)) ||
             (tamp_on && overlap(auth_ofs, `DMSC_AUTH_LEN, tamp_ofs,
                                 `DMSC_TAMPER_LEN)))
            perr = 1'b1;
      end
   end

   // Checks in priority order; only the first failing code is reported
   reg [7:0] next_code;
   always @* begin
      if (ctrl[`DMSC_CTRL_BUSY_OTHER])
         next_code = `DMSC_ABORTED;
      else if (ctrl[`DMSC_CTRL_MAC_BAD])
         next_code = `DMSC_INTEGRITY;
      else if (ctrl[`DMSC_CTRL_LEN_BAD])
         next_code = `DMSC_LENGTH;
      else if (perr)
         next_code = `DMSC_PARAM;
      else
         next_code = `DMSC_OK;
   end

   // A write commits once address and data are both held and the
   // previous response has been accepted
   wire wr_fire = wa_ok && wd_ok && !s_axi_bvalid;
   wire [31:0] wm_ctrl = merge({28'h0000000, ctrl}, wd, ws);
   // Merged images of each register for the pending write
   wire [31:0] wm_rights = merge({16'h0000, rights}, wd, ws);
   wire [31:0] wm_fsize = merge({8'h00, fsize}, wd, ws);
   wire [31:0] wm_id = merge({8'h00, id_ofs}, wd, ws);
   wire [31:0] wm_ctr = merge({8'h00, ctr_ofs}, wd, ws);
   wire [31:0] wm_card = merge({8'h00, card_ofs}, wd, ws);
   wire [31:0] wm_tamp = merge({8'h00, tamp_ofs}, wd, ws);
   wire [31:0] wm_ain = merge({8'h00, ain_ofs}, wd, ws);
   wire [31:0] wm_enc_ofs = merge({8'h00, enc_ofs}, wd, ws);
   wire [31:0] wm_enc_len = merge({8'h00, enc_len}, wd, ws);
   wire [31:0] wm_auth = merge({8'h00, auth_ofs}, wd, ws);
   wire [31:0] wm_limit = merge({8'h00, limit}, wd, ws);
   wire [31:0] wm_opt = merge({24'h000000, opt}, wd, ws);


   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         wa_ok <= 1'b0;
         wd_ok <= 1'b0;
         wa <= {AW{1'b0}};
         wd <= 32'h00000000;
         ws <= 4'h0;
         ctrl <= 4'h0;
         rights <= 16'hFFFF;
         fsize <= 24'h000000;
         id_ofs <= 24'h000000;
         ctr_ofs <= 24'h000000;
         card_ofs <= 24'h000000;
         tamp_ofs <= 24'h000000;
         ain_ofs <= 24'h000000;
         enc_ofs <= 24'h000000;
         enc_len <= 24'h000000;
         auth_ofs <= 24'h000000;
         limit <= 24'h000000;
         opt <= 8'h00;
         status_word <= 16'h0000;
         done <= 1'b0;
         stored_opt <= 8'h00;
         stored_rights <= 16'hFFFF;
      end else begin
         ctrl[`DMSC_CTRL_GO] <= 1'b0;
         if (ctrl[`DMSC_CTRL_GO]) begin
            status_word <= {`DMSC_SW1, next_code};
            done <= 1'b1;
            if (next_code == `DMSC_OK) begin
               stored_opt <= opt;
               stored_rights <= rights;
            end
         end
         if (s_axi_awvalid && s_axi_awready) begin
            wa <= s_axi_awaddr;
            wa_ok <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd <= s_axi_wdata;
            ws <= s_axi_wstrb;
            wd_ok <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            wa_ok <= 1'b0;
            wd_ok <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            if (wa == `DMSC_A_CTRL) begin
               ctrl <= wm_ctrl[3:0];
               if (wm_ctrl[`DMSC_CTRL_GO])
                  done <= 1'b0;
            end else if (wa == `DMSC_A_RIGHTS)
               rights <= wm_rights[15:0];
            else if (wa == `DMSC_A_FSIZE)
               fsize <= wm_fsize[23:0];
            else if (wa == `DMSC_A_IDOFS)
               id_ofs <= wm_id[23:0];
            else if (wa == `DMSC_A_CTROFS)
               ctr_ofs <= wm_ctr[23:0];
            else if (wa == `DMSC_A_CARDOFS)
               card_ofs <= wm_card[23:0];
            else if (wa == `DMSC_A_TAMPOFS)
               tamp_ofs <= wm_tamp[23:0];
            else if (wa == `DMSC_A_AINOFS)
               ain_ofs <= wm_ain[23:0];
            else if (wa == `DMSC_A_ENCOFS)
               enc_ofs <= wm_enc_ofs[23:0];
            else if (wa == `DMSC_A_ENCLEN)
               enc_len <= wm_enc_len[23:0];
            else if (wa == `DMSC_A_AUTHOFS)
               auth_ofs <= wm_auth[23:0];
            else if (wa == `DMSC_A_LIMIT)
               limit <= wm_limit[23:0];
            else if (wa == `DMSC_A_OPT)
               opt <= wm_opt[7:0] & 8'hF9;
            else
               s_axi_bresp <= 2'b10;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read data is looked up from araddr and captured at the handshake
   reg [31:0] rd;
   reg rd_bad;
   always @* begin
      rd = 32'h00000000;
      rd_bad = 1'b0;
      if (s_axi_araddr == `DMSC_A_CTRL)
         rd = {28'h0000000, ctrl};
      else if (s_axi_araddr == `DMSC_A_STATUS)
         rd = {15'h0000, done, status_word};
      else if (s_axi_araddr == `DMSC_A_RIGHTS)
         rd = {16'h0000, rights};
      else if (s_axi_araddr == `DMSC_A_FSIZE)
         rd = {8'h00, fsize};
      else if (s_axi_araddr == `DMSC_A_IDOFS)
         rd = {8'h00, id_ofs};
      else if (s_axi_araddr == `DMSC_A_CTROFS)
         rd = {8'h00, ctr_ofs};
      else if (s_axi_araddr == `DMSC_A_CARDOFS)
         rd = {8'h00, card_ofs};
      else if (s_axi_araddr == `DMSC_A_TAMPOFS)
         rd = {8'h00, tamp_ofs};
      else if (s_axi_araddr == `DMSC_A_AINOFS)
         rd = {8'h00, ain_ofs};
      else if (s_axi_araddr == `DMSC_A_ENCOFS)
         rd = {8'h00, enc_ofs};
      else if (s_axi_araddr == `DMSC_A_ENCLEN)
         rd = {8'h00, enc_len};
      else if (s_axi_araddr == `DMSC_A_AUTHOFS)
         rd = {8'h00, auth_ofs};
      else if (s_axi_araddr == `DMSC_A_LIMIT)
         rd = {8'h00, limit};
      else if (s_axi_araddr == `DMSC_A_OPT)
         rd = {24'h000000, opt};
      else if (s_axi_araddr == `DMSC_A_STORED)
         rd = {8'h00, stored_opt, stored_rights};
      else
         rd_bad = 1'b1;
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= rd_bad ? 2'b10 : 2'b00;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // dmsc_check
`default_nettype wire

//--- dv/dmsc_props.sv
`timescale 1ns/1ns
`default_nettype none
module dmsc_props #(
   parameter AW = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rstn);
   logic [AW-1:0] ra;
   // Address of the read in flight, to know what rdata holds
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         ra <= '0;
      else if (s_axi_arvalid && s_axi_arready)
         ra <= s_axi_araddr;
   end
   wire st_rd = s_axi_rvalid && ra == 8'h04 && s_axi_rdata[16];
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_write_locked: assert property (s_axi_bvalid |-> !s_axi_awready
      && !s_axi_wready) else $error("write taken during response");
   a_unmapped_read: assert property (s_axi_rvalid && ra > 8'h38
      |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("bad read");
   a_status_form: assert property (st_rd |-> s_axi_rdata[15:8] == 8'h91)
      else $error("status high byte wrong");
   a_status_code: assert property (st_rd
      |-> s_axi_rdata[7:0] inside {8'h00, 8'hCA, 8'h1E, 8'h7E, 8'h9E})
      else $error("unknown status");
   a_option_rfu: assert property (s_axi_rvalid && ra == 8'h34
      |-> s_axi_rdata[2:1] == 2'b00) else $error("option bits 2:1 set");
   a_field_width: assert property (s_axi_rvalid && ra == 8'h18
      |-> s_axi_rdata[31:24] == 8'h00) else $error("offset wider than 24");
endmodule // dmsc_props
`default_nettype wire

//--- dv/dmsc_host.sv
`timescale 1ns/1ns
`default_nettype none
module dmsc_host (
   input wire logic clock,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Slow mode raises ready only after valid, so responses must hold
   logic slow = 1'b0;
   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 48'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
   end
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      s_axi_bready <= !slow;
      do begin
         @(posedge clock);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready)
            s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow;
      do begin
         @(posedge clock);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready)
            s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
endmodule // dmsc_host
`default_nettype wire

//--- dv/dmsc_check_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dmsc_check_tb;
   typedef struct packed {
      logic [7:0] a1; logic [23:0] d1; logic [7:0] a2; logic [23:0] d2;
      logic [2:0] ctl; logic [7:0] code;
   } dmsc_row_t;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [31:0] base [2:13];
   logic [23:0] stored = 24'h00FFFF;
   dmsc_row_t rows [20];
   int bad_count = 0;
   int compares = 0;
   always #25 clock = ~clock;
   dmsc_check u_dmsc_check (
      .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   dmsc_host u_dmsc_host (
      .clock(clock), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      u_dmsc_host.rd(a, d, r);
      chk("read data", d, e);
      chk("read response", {30'h0, r}, {30'h0, er});
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Writes the whole settings set, then starts a check and reads the verdict
   task run(input dmsc_row_t t);
      logic [31:0] cur [2:13];
      cur = base;
      cur[t.a1[7:2]] = {8'h0, t.d1};
      cur[t.a2[7:2]] = {8'h0, t.d2};
      for (int i = 2; i < 14; i++) u_dmsc_host.wr(8'(i * 4), cur[i], r);
      u_dmsc_host.wr(8'h00, {28'h0, t.ctl, 1'b1}, r);
      d = 32'h0;
      for (int k = 0; k < 20 && d[16] !== 1'b1; k++) u_dmsc_host.rd(8'h04, d, r);
      chk("status", d, {15'h0, 1'b1, 8'h91, t.code});
      if (t.code == 8'h00)
         stored = {cur[13][7:0], cur[2][15:0]};
      rd_chk(8'h38, {8'h0, stored}, 2'b00);
   endtask
   initial begin
      base = '{32'hE0FE, 32'h80, 32'h0, 32'h14, 32'h0, 32'h7E, 32'h0,
         32'h20, 32'h20, 32'h40, 32'h0, 32'hC1};
      rows = '{
         '{8'h34,24'hC1,8'h34,24'hC1,3'd0,8'h00},
         '{8'h2C,24'h71,8'h2C,24'h71,3'd7,8'hCA},
         '{8'h34,24'hC1,8'h34,24'hC1,3'd6,8'h1E},
         '{8'h34,24'hC1,8'h34,24'hC1,3'd4,8'h7E},
         '{8'h2C,24'h71,8'h2C,24'h71,3'd0,8'h9E},
         '{8'h2C,24'h0A,8'h2C,24'h0A,3'd0,8'h9E},
         '{8'h20,24'h41,8'h20,24'h41,3'd0,8'h9E},
         '{8'h08,24'hF0FE,8'h08,24'hF0FE,3'd0,8'h9E},
         '{8'h34,24'h01,8'h34,24'h01,3'd0,8'h9E},
         '{8'h08,24'hE0F5,8'h08,24'hE0F5,3'd0,8'h9E},
         '{8'h34,24'hC9,8'h1C,24'h7E,3'd0,8'h00},
         '{8'h34,24'hC9,8'h1C,24'h7F,3'd0,8'h9E},
         '{8'h08,24'h00FF,8'h18,24'h60,3'd0,8'h00},
         '{8'h08,24'h00FF,8'h18,24'h61,3'd0,8'h9E},
         '{8'h34,24'hE1,8'h30,24'hFFFFFF,3'd0,8'h00},
         '{8'h34,24'hD1,8'h34,24'hD1,3'd0,8'h00},
         '{8'h34,24'hD1,8'h28,24'h30,3'd0,8'h9E},
         '{8'h34,24'hD1,8'h2C,24'h3F,3'd0,8'h9E},
         '{8'h34,24'hD1,8'h24,24'h21,3'd0,8'h9E},
         '{8'h34,24'hD1,8'h10,24'h28,3'd0,8'h9E}};
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         run(rows[i]);
         $display("row %0d done", i);
      end
      u_dmsc_host.slow = 1'b1;
      u_dmsc_host.wr(8'h18, 32'hFFFFFFFF, r);
      rd_chk(8'h18, 32'h00FFFFFF, 2'b00);
      s_axi_wstrb <= 4'h2;
      u_dmsc_host.wr(8'h18, 32'h00AABBCC, r);
      s_axi_wstrb <= 4'hF;
      rd_chk(8'h18, 32'h00FFBBFF, 2'b00);
      u_dmsc_host.wr(8'h34, 32'hFF, r);
      rd_chk(8'h34, 32'hF9, 2'b00);
      u_dmsc_host.wr(8'h04, 32'h0, r);
      chk("status write response", {30'h0, r}, 32'h2);
      u_dmsc_host.wr(8'h40, 32'h1, r);
      chk("unmapped write response", {30'h0, r}, 32'h2);
      rd_chk(8'h40, 32'h0, 2'b10);
      $display("register tests done");
      rstn <= 1'b0;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      rd_chk(8'h08, 32'hFFFF, 2'b00);
      rd_chk(8'h38, 32'hFFFF, 2'b00);
      rd_chk(8'h04, 32'h0, 2'b00);
      $display("reset tests done");
      close_out();
   end
   initial begin
      #3000000;
      bad_count++;
      $display("watchdog expired");
      close_out();
   end
endmodule // dmsc_check_tb
bind dmsc_check dmsc_props #(.AW(AW)) u_dmsc_props (
   .clock(clock), .rstn(rstn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
